// *** bench/host_job.sv ***
// host side of one request/done handshake
// assumes done comes from the unit on the same clk
`timescale 1ns/1ps
module host_job (
  // clock
  input wire logic clk,
  // control and answer
  input wire logic go,
  input wire logic done,
  // request flag toward the unit
  output logic     req
);
  initial req = 1'b0;
  // never drop early: the unit would lose the job
  always @(posedge clk) begin
    if (go) begin
      req <= 1'b1;
    end else if (req && done) begin
      req <= 1'b0;
    end
  end
endmodule

// *** bench/motion_req_properties.sv ***
// assertions on the motion request flags, bound into the top module
// assumes one clk domain with synchronous active-high rst
`timescale 1ns/1ps
module motion_req_properties #(
  parameter int DECEL_CYCLES = 8
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // watched ports
  input wire logic       axis_halt,
  input wire logic       axis_start_grant,
  input wire logic       axis_stopped,
  input wire logic       monitor_enable_cfg,
  input wire logic       packet_monitor_active,
  input wire logic       flash_write_active,
  input wire logic       flash_copy_finish,
  input wire logic       recalc_req,
  input wire logic       recalc_start,
  input wire logic       recalc_finish,
  input wire logic       recalc_done,
  input wire logic       cam_read_start,
  input wire logic [7:0] cam_pattern_num,
  input wire logic [7:0] cam_pattern_sel,
  input wire logic       fieldbus_halt,
  input wire logic       fieldbus_idle,
  input wire logic       comm_stopped_flag,
  input wire logic       wave_log_active,
  input wire logic       wave_log_abort,
  input wire logic       state_switch_finish,
  input wire logic       state_switch_ack
);
  logic [31:0] halt_cnt_d;
  logic [31:0] halt_cnt_q;
  // cycles spent halting; stop point allowed one cycle either way
  always_comb halt_cnt_d = axis_halt ? halt_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clk) halt_cnt_q <= rst ? 32'h0 : halt_cnt_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_no_grant: assert property (axis_halt |-> !axis_start_grant)
    else $error("axis start granted while halting");
  chk_decel_time: assert property ($rose(axis_stopped) |->
    halt_cnt_q + 1 >= DECEL_CYCLES && halt_cnt_q <= DECEL_CYCLES + 1)
    else $error("stop reached at wrong count");
  chk_capture_cfg: assert property ($rose(packet_monitor_active) |->
    $past(monitor_enable_cfg)) else $error("capture without enable");
  chk_flash_end: assert property (flash_write_active &&
    flash_copy_finish |=> !flash_write_active)
    else $error("write active stuck after finish");
  chk_recalc_clear: assert property (recalc_start |=> !recalc_done)
    else $error("recalc done kept on new request");
  chk_redo_clear: assert property ($rose(recalc_req) |->
    ##[1:4] !recalc_done) else $error("recalc done kept on re-raise");
  chk_recalc_src: assert property ($rose(recalc_done) |->
    $past(recalc_finish)) else $error("recalc done without finish");
  chk_cam_select: assert property (cam_read_start |=>
    cam_pattern_sel == $past(cam_pattern_num))
    else $error("cam pattern not taken");
  chk_comm_flag: assert property (comm_stopped_flag |->
    $past(fieldbus_halt && fieldbus_idle))
    else $error("stopped flag before bus idle");
  chk_abort_src: assert property (wave_log_abort |->
    $past(wave_log_active)) else $error("abort while not logging");
  chk_ack_src: assert property ($rose(state_switch_ack) |->
    $past(state_switch_finish)) else $error("ack without switch");
  cover property ($rose(axis_stopped));
  cover property (wave_log_abort);
  cover property ($rose(recalc_done));
endmodule
bind motion_req_unit motion_req_properties #(
  .DECEL_CYCLES(DECEL_CYCLES)
) u_props (.*);

// *** bench/tb_top.sv ***
// self-checking bench for the motion request flag block
// assumes hdl/ on the include path; engines echo starts 4 clks later
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [2:0]  j;
    logic [7:0]  cam;
    logic [15:0] tbl;
  } row_s;
  logic clk, rst, system_stop_req, packet_monitor_req, flash_write_req;
  logic group_change_req, recalc_req, cam_read_req, cam_rewrite_req;
  logic comm_stop_req, wave_log_enable, state_switch_req;
  logic monitor_enable_cfg, axis_start_req, axis_start_grant, axis_halt;
  logic axis_stopped, packet_captured, packet_monitor_active;
  logic flash_copy_start, flash_copy_finish, flash_copy_ok;
  logic flash_write_active, group_apply_start, group_apply_finish;
  logic group_change_done, recalc_start, recalc_finish, recalc_done;
  logic cam_read_start, cam_rewrite_start, cam_read_finish;
  logic cam_rewrite_finish, cam_read_done, cam_rewrite_done;
  logic fieldbus_halt, fieldbus_idle, comm_stopped_flag, wave_log_start;
  logic wave_log_finish, wave_log_active, wave_log_abort;
  logic state_switch_start, state_switch_finish, state_switch_ack;
  logic [7:0]  cam_pattern_num, cam_pattern_sel;
  logic [15:0] recalc_start_table, packet_bytes, recalc_from_table;
  logic [15:0] flash_write_result_word;
  logic [4:0]  go, rq, dn;
  logic [5:0]  st;
  logic [5:0]  stg [4];
  int          error_cnt, n_tests, cycles;
  row_s        rows [6] = '{{3'd0, 8'h00, 16'h0000},
    {3'd1, 8'h00, 16'h0000}, {3'd1, 8'h00, 16'hffff},
    {3'd2, 8'hff, 16'h0000}, {3'd3, 8'h5a, 16'h0000},
    {3'd4, 8'h00, 16'h0000}};
  motion_req_unit #(.DECEL_CYCLES(8)) dut (.*);
  for (genvar i = 0; i < 5; i++) begin : g_host
    host_job u_host (.clk(clk), .go(go[i]), .done(dn[i]), .req(rq[i]));
  end
  assign {state_switch_req, cam_rewrite_req, cam_read_req, recalc_req,
    group_change_req} = rq;
  assign dn = {state_switch_ack, cam_rewrite_done, cam_read_done,
    recalc_done, group_change_done};
  assign st = {flash_copy_start, state_switch_start, cam_rewrite_start,
    cam_read_start, recalc_start, group_apply_start};
  assign {flash_copy_finish, state_switch_finish, cam_rewrite_finish,
    cam_read_finish, recalc_finish, group_apply_finish} = stg[3];
  // engines answer after a fixed four-cycle delay
  always @(posedge clk) begin
    stg[0] <= st;
    for (int i = 1; i < 4; i++) stg[i] <= stg[i-1];
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("tests=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic mon(input logic v, input logic exp);
    packet_monitor_req <= v;
    cyc(6);
    check(packet_monitor_active, exp);
  endtask
  task automatic feed(input int n);
    repeat (n) begin
      packet_captured <= 1'b1;
      cyc(1);
    end
    packet_captured <= 1'b0;
    cyc(3);
  endtask
  // hang guard, run needs well under 10000 clks
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    int n;
    logic seen;
    row_s r;
    {error_cnt, n_tests, cycles, n} = '0;
    foreach (stg[i]) stg[i] = '0;
    {rst, go, system_stop_req, packet_monitor_req, flash_write_req} = '1;
    {go, system_stop_req, packet_monitor_req, flash_write_req} = '0;
    {comm_stop_req, wave_log_enable, monitor_enable_cfg} = '0;
    {axis_start_req, packet_captured, flash_copy_ok, fieldbus_idle} = '0;
    {wave_log_start, wave_log_finish, cam_pattern_num} = '0;
    {recalc_start_table, packet_bytes} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    check({axis_halt, axis_stopped, packet_monitor_active, recalc_done,
      flash_write_active, comm_stopped_flag, wave_log_active}, 16'h0);
    check(flash_write_result_word, 16'h0000);
    $display("test reset done");
    foreach (rows[k]) begin
      r = rows[k];
      {cam_pattern_num, recalc_start_table} <= {r.cam, r.tbl};
      go[r.j] <= 1'b1;
      cyc(1);
      go <= '0;
      for (n = 0; n < 40 && dn[r.j] !== 1'b1; n++) cyc(1);
      check(dn[r.j], 1'b1);
      if (r.j == 3'd1) check(recalc_from_table, r.tbl);
      if (r.j == 3'd2) check(cam_pattern_sel, r.cam);
      if (r.j == 3'd3) check(cam_pattern_sel, r.cam);
      cyc(8);
      check(dn[r.j], 1'b0);
    end
    // quick drop and re-raise: done must fall before the new completion
    go[1] <= 1'b1;
    cyc(1);
    go[1] <= 1'b0;
    for (n = 0; n < 40 && recalc_done !== 1'b1; n++) cyc(1);
    check(recalc_done, 1'b1);
    go[1] <= 1'b1;
    cyc(1);
    go[1] <= 1'b0;
    cyc(3);
    check(recalc_done, 1'b0);
    for (n = 0; n < 40 && recalc_done !== 1'b1; n++) cyc(1);
    check(recalc_done, 1'b1);
    cyc(8);
    check(recalc_done, 1'b0);
    $display("test handshake rows done");
    for (n = 0; n < 2; n++) begin
      flash_copy_ok <= n[0];
      flash_write_req <= 1'b1;
      cyc(5);
      check(flash_write_active, 1'b1);
      cyc(7);
      check(flash_write_active, 1'b0);
      check(flash_write_result_word, n ? 16'h0000 : 16'h0001);
      flash_write_req <= 1'b0;
      cyc(5);
    end
    $display("test flash done");
    axis_start_req <= 1'b1;
    cyc(2);
    check(axis_start_grant, 1'b1);
    system_stop_req <= 1'b1;
    cyc(5);
    check({axis_halt, axis_start_grant, axis_stopped}, 16'h4);
    cyc(10);
    check(axis_stopped, 1'b1);
    system_stop_req <= 1'b0;
    cyc(5);
    check(axis_start_grant, 1'b1);
    $display("test stop done");
    mon(1'b1, 1'b0);
    mon(1'b0, 1'b0);
    monitor_enable_cfg <= 1'b1;
    mon(1'b1, 1'b1);
    mon(1'b0, 1'b0);
    packet_bytes <= 16'h0001;
    mon(1'b1, 1'b1);
    feed(3903);
    check(packet_monitor_active, 1'b1);
    feed(1);
    check(packet_monitor_active, 1'b0);
    mon(1'b0, 1'b0);
    packet_bytes <= 16'hffff;
    mon(1'b1, 1'b1);
    feed(96);
    check(packet_monitor_active, 1'b1);
    feed(1);
    check(packet_monitor_active, 1'b0);
    mon(1'b0, 1'b0);
    $display("test capture done");
    comm_stop_req <= 1'b1;
    cyc(5);
    check({fieldbus_halt, comm_stopped_flag}, 16'h2);
    fieldbus_idle <= 1'b1;
    cyc(3);
    check(comm_stopped_flag, 1'b1);
    comm_stop_req <= 1'b0;
    cyc(5);
    check({fieldbus_halt, comm_stopped_flag}, 16'h0);
    $display("test comm stop done");
    for (n = 0; n < 2; n++) begin
      wave_log_enable <= n[0];
      cyc(4);
      wave_log_start <= 1'b1;
      cyc(1);
      wave_log_start <= 1'b0;
      cyc(3);
      check(wave_log_active, n[0]);
    end
    wave_log_enable <= 1'b0;
    seen = 1'b0;
    repeat (6) begin
      cyc(1);
      if (wave_log_abort === 1'b1) seen = 1'b1;
    end
    check(seen, 1'b1);
    check(wave_log_active, 1'b0);
    $display("test logging done");
    summarize();
  end
endmodule

// *** hdl/motion_req_pkg.sv ***
// types for the motion unit request handshake block
// assumes nothing beyond the constants header
package motion_req_pkg;
  typedef enum logic [1:0] {
    JOB_IDLE = 2'b00,
    JOB_BUSY = 2'b01,
    JOB_DONE = 2'b10
  } job_e;
endpackage

// *** hdl/motion_req_regs.svh ***
// constants for the motion unit request handshake block
// assumes a 50 mhz clk; included by the top module only
// Notes on behaviour
// - system stop halts all axes using a 1 ms deceleration time.
// - while system stop is held, no axis operation may start.
// - packet capture starts on request only if monitor enable is set.
// - packet capture stops as soon as the request is dropped.
// - capture ends itself at 6 Mbytes or 3904 packets, clearing active.
// - flash write copies data, active flag high during copy only.
// - each flash write outcome is recorded in a result word.
// - recalculation rebuilds tables from the start number and enables them.
// - cam read request rising edge reads the selected cam pattern.
// - cam rewrite request rising edge overwrites the selected cam pattern.
// - comm stop request halts fieldbus, then raises stopped flag.
// - dropping comm stop request restarts fieldbus communication.
// - waveform logging runs only while logging enable is high.
// - logging enable falling during logging aborts the logging.
// - state switch request changes network state, then raises ack.
// - state switch ack clears when the request falls.
// - recalc request raised again first clears recalc done.
`ifndef MOTION_REQ_REGS_SVH
`define MOTION_REQ_REGS_SVH
`define CLK_HZ            50000000
`define DECEL_TIME_US     1000
`define DECEL_CYCLES      ((`CLK_HZ / 1000000) * `DECEL_TIME_US)
`define CAP_MAX_BYTES     (6 * 1024 * 1024)
`define CAP_MAX_PACKETS   3904
`define RESULT_OK         16'h0000
`define RESULT_FAIL       16'h0001
`endif

// *** hdl/motion_req_unit.sv ***
// request/acknowledge flag handling of the motion unit
// assumes host flags arrive asynchronously; engines answer on clk
`timescale 1ns/1ps
`include "motion_req_regs.svh"
module motion_req_unit #(
  parameter int DECEL_CYCLES = `DECEL_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // host request flags
  input  wire logic        system_stop_req,
  input  wire logic        packet_monitor_req,
  input  wire logic        flash_write_req,
  input  wire logic        group_change_req,
  input  wire logic        recalc_req,
  input  wire logic        cam_read_req,
  input  wire logic        cam_rewrite_req,
  input  wire logic        comm_stop_req,
  input  wire logic        wave_log_enable,
  input  wire logic        state_switch_req,
  // configuration
  input  wire logic        monitor_enable_cfg,
  input  wire logic [7:0]  cam_pattern_num,
  input  wire logic [15:0] recalc_start_table,
  // axis control
  input  wire logic        axis_start_req,
  output logic             axis_start_grant,
  output logic             axis_halt,
  output logic             axis_stopped,
  // packet capture engine
  input  wire logic        packet_captured,
  input  wire logic [15:0] packet_bytes,
  output logic             packet_monitor_active,
  // flash engine
  output logic             flash_copy_start,
  input  wire logic        flash_copy_finish,
  input  wire logic        flash_copy_ok,
  output logic             flash_write_active,
  output logic [15:0]      flash_write_result_word,
  // group change
  output logic             group_apply_start,
  input  wire logic        group_apply_finish,
  output logic             group_change_done,
  // recalculation
  output logic             recalc_start,
  output logic [15:0]      recalc_from_table,
  input  wire logic        recalc_finish,
  output logic             recalc_done,
  // cam tables
  output logic             cam_read_start,
  output logic             cam_rewrite_start,
  output logic [7:0]       cam_pattern_sel,
  input  wire logic        cam_read_finish,
  input  wire logic        cam_rewrite_finish,
  output logic             cam_read_done,
  output logic             cam_rewrite_done,
  // fieldbus
  output logic             fieldbus_halt,
  input  wire logic        fieldbus_idle,
  output logic             comm_stopped_flag,
  // waveform logging
  input  wire logic        wave_log_start,
  input  wire logic        wave_log_finish,
  output logic             wave_log_active,
  output logic             wave_log_abort,
  // network state switch
  output logic             state_switch_start,
  input  wire logic        state_switch_finish,
  output logic             state_switch_ack
);
  import motion_req_pkg::*;

  // elaboration check: a zero count would skip deceleration entirely
  if (DECEL_CYCLES < 1) begin : g_bad_decel
    $error("DECEL_CYCLES must be at least one");
  end

  localparam int NREQ = 10;
  localparam logic [31:0] CAP_BYTES = 32'(`CAP_MAX_BYTES);
  localparam logic [11:0] CAP_PKTS = 12'(`CAP_MAX_PACKETS);

  // two-stage synchronisers, one per host flag
  logic [NREQ-1:0] raw, s1_q, s2_q;
  assign raw = {state_switch_req, wave_log_enable, comm_stop_req,
                cam_rewrite_req, cam_read_req, recalc_req,
                group_change_req, flash_write_req, packet_monitor_req,
                system_stop_req};
  genvar g;
  generate
    for (g = 0; g < NREQ; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  logic stop_s, mon_s, fw_s, grp_s, rc_s, cr_s, cw_s, cs_s, wl_s, sw_s;
  assign {sw_s, wl_s, cs_s, cw_s, cr_s, rc_s, grp_s, fw_s, mon_s,
          stop_s} = s2_q;

  // system stop and deceleration timer
  logic [31:0] dec_cnt_q, dec_cnt_d;
  logic        halt_q, halt_d;
  always_comb begin
    halt_d    = halt_q;
    dec_cnt_d = dec_cnt_q;
    if (stop_s && !halt_q) begin
      halt_d    = 1'b1;
      dec_cnt_d = 32'(DECEL_CYCLES);
    end else if (!stop_s) begin
      halt_d    = 1'b0;
      dec_cnt_d = 32'h0;
    end else if (dec_cnt_q != 32'h0) begin
      dec_cnt_d = dec_cnt_q - 32'h1;
    end
  end
  assign axis_halt        = halt_q;
  assign axis_stopped     = halt_q & (dec_cnt_q == 32'h0);
  assign axis_start_grant = axis_start_req & ~stop_s & ~halt_q;

  // packet capture with byte and packet limits
  logic        mon_q, mon_d, mon_req_q;
  logic [31:0] cap_bytes_q, cap_bytes_d;
  logic [11:0] cap_pkts_q, cap_pkts_d;
  always_comb begin
    mon_d       = mon_q;
    cap_bytes_d = cap_bytes_q;
    cap_pkts_d  = cap_pkts_q;
    if (!mon_s) begin
      mon_d = 1'b0;
    end else if (!mon_req_q && monitor_enable_cfg) begin
      mon_d       = 1'b1;
      cap_bytes_d = 32'h0;
      cap_pkts_d  = 12'h0;
    end else if (mon_q && packet_captured) begin
      cap_bytes_d = cap_bytes_q + {16'h0, packet_bytes};
      cap_pkts_d  = cap_pkts_q + 12'h1;
      if (cap_bytes_d >= CAP_BYTES || cap_pkts_d >= CAP_PKTS) begin
        mon_d = 1'b0;
      end
    end
  end
  assign packet_monitor_active = mon_q;

  // flash write: active while the copy runs, result latched on finish
  logic [15:0] result_q, result_d;
  req_job u_flash (
    .clk    (clk),
    .rst    (rst),
    .req    (fw_s),
    .allow  (1'b1),
    .start  (flash_copy_start),
    .busy   (flash_write_active),
    .finish (flash_copy_finish),
    .done   ()
  );
  always_comb begin
    result_d = result_q;
    if (flash_write_active && flash_copy_finish) begin
      result_d = flash_copy_ok ? `RESULT_OK : `RESULT_FAIL;
    end
  end
  assign flash_write_result_word = result_q;

  // group change; host holds request until done
  req_job u_group (
    .clk    (clk),
    .rst    (rst),
    .req    (grp_s),
    .allow  (1'b1),
    .start  (group_apply_start),
    .busy   (),
    .finish (group_apply_finish),
    .done   (group_change_done)
  );

  // recalculation; re-raise clears done first inside the job
  req_job u_recalc (
    .clk    (clk),
    .rst    (rst),
    .req    (rc_s),
    .allow  (1'b1),
    .start  (recalc_start),
    .busy   (),
    .finish (recalc_finish),
    .done   (recalc_done)
  );

  // cam read and rewrite share the pattern selector
  req_job u_cam_rd (
    .clk    (clk),
    .rst    (rst),
    .req    (cr_s),
    .allow  (1'b1),
    .start  (cam_read_start),
    .busy   (),
    .finish (cam_read_finish),
    .done   (cam_read_done)
  );
  req_job u_cam_wr (
    .clk    (clk),
    .rst    (rst),
    .req    (cw_s),
    .allow  (1'b1),
    .start  (cam_rewrite_start),
    .busy   (),
    .finish (cam_rewrite_finish),
    .done   (cam_rewrite_done)
  );

  // network state switch
  req_job u_state (
    .clk    (clk),
    .rst    (rst),
    .req    (sw_s),
    .allow  (1'b1),
    .start  (state_switch_start),
    .busy   (),
    .finish (state_switch_finish),
    .done   (state_switch_ack)
  );

  // operands captured on start so host changes mid-job do no harm
  logic [15:0] rc_from_q, rc_from_d;
  logic [7:0]  cam_sel_q, cam_sel_d;
  always_comb begin
    rc_from_d = recalc_start ? recalc_start_table : rc_from_q;
    cam_sel_d = (cam_read_start | cam_rewrite_start) ?
                cam_pattern_num : cam_sel_q;
  end
  assign recalc_from_table = rc_from_q;
  assign cam_pattern_sel   = cam_sel_q;

  // fieldbus stop: flag only after traffic really idles
  logic cstop_q, cstop_d;
  always_comb begin
    cstop_d = cs_s & fieldbus_idle;
  end
  assign fieldbus_halt     = cs_s;
  assign comm_stopped_flag = cstop_q;

  // waveform logging gated by enable, aborted when enable falls
  logic wl_q, wl_d, abort_q, abort_d;
  always_comb begin
    wl_d    = wl_q;
    abort_d = 1'b0;
    if (!wl_s) begin
      abort_d = wl_q;
      wl_d    = 1'b0;
    end else if (wave_log_start && !wl_q) begin
      wl_d = 1'b1;
    end else if (wave_log_finish) begin
      wl_d = 1'b0;
    end
  end
  assign wave_log_active = wl_q;
  assign wave_log_abort  = abort_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      halt_q      <= 1'b0;
      dec_cnt_q   <= 32'h0;
      mon_q       <= 1'b0;
      mon_req_q   <= 1'b0;
      cap_bytes_q <= 32'h0;
      cap_pkts_q  <= 12'h0;
      result_q    <= `RESULT_OK;
      rc_from_q   <= 16'h0;
      cam_sel_q   <= 8'h0;
      cstop_q     <= 1'b0;
      wl_q        <= 1'b0;
      abort_q     <= 1'b0;
    end else begin
      halt_q      <= halt_d;
      dec_cnt_q   <= dec_cnt_d;
      mon_q       <= mon_d;
      mon_req_q   <= mon_s;
      cap_bytes_q <= cap_bytes_d;
      cap_pkts_q  <= cap_pkts_d;
      result_q    <= result_d;
      rc_from_q   <= rc_from_d;
      cam_sel_q   <= cam_sel_d;
      cstop_q     <= cstop_d;
      wl_q        <= wl_d;
      abort_q     <= abort_d;
    end
  end
endmodule

// *** hdl/req_job.sv ***
// one request/acknowledge job: start on a rising request, hand work to
// the engine, raise done when the engine finishes, clear done on release
// assumes request is already synchronised to clk
`timescale 1ns/1ps
module req_job (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // request side
  input  wire logic              req,
  input  wire logic              allow,
  // engine side
  output logic                   start,
  output logic                   busy,
  input  wire logic              finish,
  // answer
  output logic                   done
);
  import motion_req_pkg::*;
  job_e st_q, st_d;
  logic req_q;
  logic rise;

  assign rise  = req & ~req_q;
  assign start = (st_q == JOB_IDLE) & rise & allow;
  assign busy  = (st_q == JOB_BUSY);
  assign done  = (st_q == JOB_DONE);

  always_comb begin
    st_d = st_q;
    case (st_q)
      JOB_IDLE: begin
        if (start) begin
          st_d = JOB_BUSY;
        end
      end
      JOB_BUSY: begin
        if (finish) begin
          st_d = JOB_DONE;
        end
      end
      JOB_DONE: begin
        // release or re-raise clears done before a new completion
        if (!req || rise) begin
          st_d = JOB_IDLE;
        end
      end
      default: st_d = JOB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= JOB_IDLE;
      req_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      req_q <= req;
    end
  end
endmodule
